// file: bench/ebw_acc_model.sv
// cpu and dma requester on the external access side
`timescale 1ns/1ps
`default_nettype none
module ebw_acc_model (
	input  wire logic       clk,
	output var  logic       accValid,
	output var  logic       accFromDma,
	output var  logic [1:0] accRegion,
	input  wire logic       accDone,
	input  wire logic [1:0] accWidth,
	input  wire logic       accAbort,
	input  wire logic       accError
);
	// idle until asked
	initial begin
		accValid = 1'b0;
		accFromDma = 1'b0;
		accRegion = 2'h0;
	end
	// one-cycle request, answer caught in the following cycle
	task access(input logic dma, input logic [1:0] region, output logic [4:0] res);
		accValid <= 1'b1;
		accFromDma <= dma;
		accRegion <= region;
		@(posedge clk);
		accValid <= 1'b0;
		accFromDma <= ~dma;     // qualifiers no longer meaningful
		accRegion <= ~region;
		@(negedge clk);
		res = {accDone, accWidth, accAbort, accError};
		@(posedge clk);
	endtask
endmodule // ebw_acc_model
`default_nettype wire

// file: bench/ebw_bw_props.sv
// assertions on the access answers of the width register block
`timescale 1ns/1ps
`default_nettype none
module ebw_bw_props (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       ce,
	input wire logic       accValid,
	input wire logic       accFromDma,
	input wire logic [1:0] accRegion,
	input wire logic       accDone,
	input wire logic [1:0] accWidth,
	input wire logic       accAbort,
	input wire logic       accError,
	input wire logic [1:0] romWidth,
	input wire logic [1:0] sramWidth,
	input wire logic [1:0] io01Width,
	input wire logic [1:0] io23Width
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire take = ce && accValid;     // request taken this edge
	wire cpu  = take && !accFromDma; // cpu request
	wire dma  = take && accFromDma;  // dma request
	done_lat_a: assert property (take |=> accDone) else $error("late answer");
	rom_abort_a: assert property (cpu && accRegion == 2'h0 && romWidth == 2'h0 |=> accAbort)
		else $error("rom abort missing");
	sram_abort_a: assert property (cpu && accRegion == 2'h1 && sramWidth == 2'h0 |=> accAbort)
		else $error("sram abort missing");
	dma_noabort_a: assert property (dma |=> !accAbort) else $error("dma aborted");
	dma_sram_a: assert property (dma && accRegion == 2'h1 && sramWidth == 2'h0 |=> accError)
		else $error("sram error missing");
	dma_io01_a: assert property (dma && accRegion == 2'h2 && io01Width == 2'h0 |=> accError)
		else $error("io01 error missing");
	dma_io23_a: assert property (dma && accRegion == 2'h3 && io23Width == 2'h0 |=> accError)
		else $error("io23 error missing");
	rom_width_a: assert property (take && accRegion == 2'h0 |=> accWidth == $past(romWidth))
		else $error("rom width wrong");
	io01_width_a: assert property (take && accRegion == 2'h2 |=> accWidth == $past(io01Width))
		else $error("io01 width wrong");
	cover property (accDone && accAbort);
	cover property (accDone && accError);
	cover property (accDone && accWidth == 2'h1);
endmodule // ebw_bw_props
bind ebw_bus_width_regs ebw_bw_props u_props (.*);
`default_nettype wire

// file: bench/test_external_bus_width_config.sv
// self-checking bench for the bus width register block
`timescale 1ns/1ps
`default_nettype none
module test_external_bus_width_config;
	logic clk = 1'b0, rst_b = 1'b0;
	logic [31:0] s_awaddr = '0, s_wdata = '0, s_araddr = '0, rd;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	wire logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, accValid, accFromDma;
	wire logic accDone, accAbort, accError;
	wire logic [1:0] s_bresp, s_rresp, accRegion, accWidth;
	wire logic [31:0] s_rdata;
	logic [1:0] rsp;
	logic [4:0] res;
	int failures = 0, checked = 0, cycles = 0;
	// rows: written word, read back, {dma, region}, {done, width, abort, error}
	logic [31:0] rowW[6] = '{32'hfffffea8, 32'h68, 32'h8, 32'h8, 32'h20, 32'h8};
	logic [31:0] rowR[6] = '{32'ha8, 32'h68, 32'h8, 32'h8, 32'h20, 32'h8};
	logic [2:0] rowQ[6] = '{3'h0, 3'h6, 3'h1, 3'h5, 3'h0, 3'h6};
	logic [4:0] rowE[6] = '{5'h18, 5'h14, 5'h12, 5'h11, 5'h12, 5'h11};
	always #12.5 clk = ~clk;
	ebw_bus_width_regs DUT (.clk, .rst_b, .ce(1'b1), .s_awaddr, .s_awvalid, .s_awready,
		.s_wdata, .s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
		.s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
		.accValid, .accFromDma, .accRegion, .accDone, .accWidth, .accAbort, .accError,
		.romWidth(), .sramWidth(), .io01Width(), .io23Width());
	ebw_acc_model MDL (.clk, .accValid, .accFromDma, .accRegion, .accDone, .accWidth,
		.accAbort, .accError);
	task test_done;
		if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// word comparison
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	// access answer comparison
	task chkAcc(input string n, input logic [4:0] e, input logic [4:0] s);
		chk(n, {27'h0, e}, {27'h0, s});
	endtask
	// axi write, both halves offered together
	task axW(input logic [31:0] a, input logic [31:0] d);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (!s_bvalid);
		rsp = s_bresp;
	endtask
	// axi read
	task axR(input logic [31:0] a);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_arready) s_arvalid <= 1'b0;
		end while (!s_rvalid);
		rd = s_rdata;
		rsp = s_rresp;
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			test_done;
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		axR(32'h78100000);
		chk("bwc reset", 32'h8, rd);
		axR(32'h78300000);
		chk("io23 reset", 32'h0, rd);
		for (int i = 0; i < 6; i++) begin
			axW(32'h78100000, rowW[i]);
			axR(32'h78100000);
			chk("bwc", rowR[i], rd);
			MDL.access(rowQ[i][2], rowQ[i][1:0], res);
			chkAcc("acc", rowE[i], res);
		end
		axW(32'h78300000, 32'hffffff40);
		axR(32'h78300000);
		chk("io23", 32'h40, rd);
		MDL.access(1'b1, 2'h3, res);
		chkAcc("io23 acc", 5'h14, res);
		axW(32'h78300000, 32'h0);
		MDL.access(1'b1, 2'h3, res);
		chkAcc("io23 err", 5'h11, res);
		axR(32'h78100004);
		chk("unmapped", 32'h3, {30'h0, rsp});
		test_done;
	end
endmodule // test_external_bus_width_config
`default_nettype wire

// file: common/ebw_consts.vh
// constants for the external bus width configuration block
`ifndef EBW_CONSTS_VH
`define EBW_CONSTS_VH

// register byte addresses (decoded on address bits 31:2 inside the slave)
`define EBW_BWC_ADDR        32'h78100000
`define EBW_IO23_ADDR       32'h78300000
// field positions in the main width register
`define EBW_ROM_LSB         2
`define EBW_SRAM_LSB        4
`define EBW_IO01_LSB        6
`define EBW_IO23_LSB        8
// field position in the separate bank 2/3 register
`define EBW_IO23B_LSB       6
// reset values
`define EBW_BWC_RESET       32'h00000008
`define EBW_ROM_RESET       2'h2
`define EBW_IO23_RESET      32'h00000000
// width codes
`define EBW_W_ABSENT        2'h0
`define EBW_W_8BIT          2'h1
`define EBW_W_16BIT         2'h2
// axi responses
`define EBW_RESP_OKAY       2'h0
`define EBW_RESP_SLVERR     2'h2
`define EBW_RESP_DECERR     2'h3
// region select codes for external accesses
`define EBW_REG_ROM         2'h0
`define EBW_REG_SRAM        2'h1
`define EBW_REG_IO01        2'h2
`define EBW_REG_IO23        2'h3

`endif

// file: rtl/ebw_bus_width_regs.v
// bus width configuration registers with axi4-lite slave
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "ebw_consts.vh"

module ebw_bus_width_regs #(
	parameter SEPARATE_IO23 = 1    // 1: bank 2/3 width in own register
) (
	input  wire        clk,         // system clock
	input  wire        rst_b,       // async reset, active low
	input  wire        ce,          // clock enable, freezes state when low
	// axi4-lite write address
	input  wire [31:0] s_awaddr,
	input  wire        s_awvalid,
	output wire        s_awready,
	// axi4-lite write data
	input  wire [31:0] s_wdata,
	input  wire [3:0]  s_wstrb,
	input  wire        s_wvalid,
	output wire        s_wready,
	// axi4-lite write response
	output reg  [1:0]  s_bresp,
	output reg         s_bvalid,
	input  wire        s_bready,
	// axi4-lite read address
	input  wire [31:0] s_araddr,
	input  wire        s_arvalid,
	output wire        s_arready,
	// axi4-lite read data
	output reg  [31:0] s_rdata,
	output reg  [1:0]  s_rresp,
	output reg         s_rvalid,
	input  wire        s_rready,
	// external access requests from cpu or dma side
	input  wire        accValid,    // one-cycle request
	input  wire        accFromDma,  // 1 = dma
	input  wire [1:0]  accRegion,   // region select
	output wire        accDone,     // answer pulse
	output wire [1:0]  accWidth,    // width code for the access
	output wire        accAbort,    // cpu abort answer
	output wire        accError,    // dma error answer
	// current widths for the bus sequencer
	output wire [1:0]  romWidth,
	output wire [1:0]  sramWidth,
	output wire [1:0]  io01Width,
	output wire [1:0]  io23Width
);
	reg  [1:0]  romReg;            // rom width field
	reg  [1:0]  sramReg;           // sram width field
	reg  [1:0]  io01Reg;           // bank 0/1 width field
	reg  [1:0]  io23Reg;           // bank 2/3 width field
	reg         awHeld;            // write address taken
	reg  [31:0] awAddr;            // held write address
	reg         wHeld;             // write data taken
	reg  [31:0] wData;             // held write data
	reg  [3:0]  wStrb;             // held strobes
	wire        doWrite;           // both halves present
	wire [31:0] bwcView;           // main register readback
	wire [31:0] io23View;          // bank 2/3 register readback

	// true when an address hits the given register word
	function hit;
		input [31:0] a;
		input [31:0] base;
		begin
			hit = (a[31:2] == base[31:2]);
		end
	endfunction

	// readback images; unassigned bits are zero
	assign bwcView = {22'h000000,
		(SEPARATE_IO23 ? 2'h0 : io23Reg),
		io01Reg, sramReg, romReg, 2'h0};
	assign io23View = {24'h000000, (SEPARATE_IO23 ? io23Reg : 2'h0), 6'h00};

	// ready while the half is not yet held and no response pending
	assign s_awready = !awHeld && !s_bvalid;
	assign s_wready  = !wHeld && !s_bvalid;
	assign s_arready = !s_rvalid;
	assign doWrite   = awHeld && wHeld && !s_bvalid;

	// write channel: take address and data in any order
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			awHeld   <= 1'b0;
			awAddr   <= 32'h00000000;
			wHeld    <= 1'b0;
			wData    <= 32'h00000000;
			wStrb    <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp  <= `EBW_RESP_OKAY;
		end else if (ce) begin
			// capture address
			if (s_awvalid && s_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_awaddr;
			end
			// capture data
			if (s_wvalid && s_wready) begin
				wHeld <= 1'b1;
				wData <= s_wdata;
				wStrb <= s_wstrb;
			end
			// perform write and answer
			if (doWrite) begin
				awHeld   <= 1'b0;
				wHeld    <= 1'b0;
				s_bvalid <= 1'b1;
				if (hit(awAddr, `EBW_BWC_ADDR) ||
					(SEPARATE_IO23 && hit(awAddr, `EBW_IO23_ADDR)))
					s_bresp <= `EBW_RESP_OKAY;
				else
					s_bresp <= `EBW_RESP_DECERR;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// width fields: low byte lane holds assigned bits, plus lane 1 for the bank 2/3 field when SEPARATE_IO23 is 0
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			romReg  <= `EBW_ROM_RESET; // rom field of the main reset word
			sramReg <= 2'h0;
			io01Reg <= 2'h0;
			io23Reg <= 2'h0;
		end else if (ce && doWrite) begin
			if (hit(awAddr, `EBW_BWC_ADDR)) begin
				if (wStrb[0]) begin
					romReg  <= wData[`EBW_ROM_LSB +: 2];
					sramReg <= wData[`EBW_SRAM_LSB +: 2];
					io01Reg <= wData[`EBW_IO01_LSB +: 2];
				end
				if (wStrb[1] && !SEPARATE_IO23)
					io23Reg <= wData[`EBW_IO23_LSB +: 2];
			end else if (SEPARATE_IO23 && hit(awAddr, `EBW_IO23_ADDR)) begin
				if (wStrb[0])
					io23Reg <= wData[`EBW_IO23B_LSB +: 2];
			end
		end
	end

	// read channel: one-cycle answer from flops
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h00000000;
			s_rresp  <= `EBW_RESP_OKAY;
		end else if (ce) begin
			if (s_arvalid && s_arready) begin
				s_rvalid <= 1'b1;
				if (hit(s_araddr, `EBW_BWC_ADDR)) begin
					s_rdata <= bwcView;
					s_rresp <= `EBW_RESP_OKAY;
				end else if (SEPARATE_IO23 && hit(s_araddr, `EBW_IO23_ADDR)) begin
					s_rdata <= io23View;
					s_rresp <= `EBW_RESP_OKAY;
				end else begin
					s_rdata <= 32'h00000000;
					s_rresp <= `EBW_RESP_DECERR;
				end
			end else if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end

	// widths go straight to the sequencer; effect after write edge
	assign romWidth  = romReg;
	assign sramWidth = sramReg;
	assign io01Width = io01Reg;
	assign io23Width = io23Reg;

	// per-access width lookup and refusal
	ebw_region_check u_check (
		.clk        (clk),
		.rst_b      (rst_b),
		.ce         (ce),
		.reqValid   (accValid),
		.reqFromDma (accFromDma),
		.reqRegion  (accRegion),
		.romWidth   (romReg),
		.sramWidth  (sramReg),
		.io01Width  (io01Reg),
		.io23Width  (io23Reg),
		.rspValid   (accDone),
		.rspWidth   (accWidth),
		.rspAbort   (accAbort),
		.rspError   (accError)
	);
endmodule // ebw_bus_width_regs
`default_nettype wire

// file: rtl/ebw_region_check.v
// region access checker: looks up width and decides abort or error
`timescale 1ns/1ps
`default_nettype none
`include "ebw_consts.vh"

module ebw_region_check (
	input  wire       clk,        // system clock
	input  wire       rst_b,      // async reset, active low
	input  wire       ce,         // clock enable
	input  wire       reqValid,   // access request pulse
	input  wire       reqFromDma, // 1 = dma, 0 = cpu
	input  wire [1:0] reqRegion,  // region select
	input  wire [1:0] romWidth,   // current rom width
	input  wire [1:0] sramWidth,  // current sram width
	input  wire [1:0] io01Width,  // current bank 0/1 width
	input  wire [1:0] io23Width,  // current bank 2/3 width
	output reg        rspValid,   // answer pulse
	output reg  [1:0] rspWidth,   // width to use
	output reg        rspAbort,   // cpu abort
	output reg        rspError    // dma error
);
	reg [1:0] selWidth;           // width of the chosen region

	// pick the region's width
	always @* begin
		case (reqRegion)
			`EBW_REG_ROM:  selWidth = romWidth;
			`EBW_REG_SRAM: selWidth = sramWidth;
			`EBW_REG_IO01: selWidth = io01Width;
			default:       selWidth = io23Width;
		endcase
	end

	// register the answer one cycle after the request
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rspValid <= 1'b0;
			rspWidth <= 2'h0;
			rspAbort <= 1'b0;
			rspError <= 1'b0;
		end else if (ce) begin
			rspValid <= reqValid;
			rspWidth <= selWidth;
			// cpu aborts only on absent rom or sram
			rspAbort <= reqValid && !reqFromDma && (selWidth == `EBW_W_ABSENT)
				&& (reqRegion == `EBW_REG_ROM || reqRegion == `EBW_REG_SRAM);
			// dma errors on absent sram or io banks
			rspError <= reqValid && reqFromDma && (selWidth == `EBW_W_ABSENT)
				&& (reqRegion != `EBW_REG_ROM);
		end
	end
endmodule // ebw_region_check
`default_nettype wire
